// >>> tmwc_pkg.sv
/*
  Shared constants and types for the tag memory write control block.
  Assumes a single 100 MHz clock and block addresses carried as one byte.
*/
package tmwc_pkg;
  localparam int BLK_W = 32;
  // command codes of the reduced command set
  localparam logic [7:0] CMD_READ = 8'h08;
  localparam logic [7:0] CMD_WRITE = 8'h09;
  localparam logic [7:0] CMD_SELECT = 8'h0e;
  // block map
  localparam logic [7:0] BLK_OTP_LAST = 8'h04;
  localparam logic [7:0] BLK_CNT_A = 8'h05;
  localparam logic [7:0] BLK_CNT_RELOAD = 8'h06;
  localparam logic [7:0] BLK_USER_FIRST = 8'h07;
  localparam logic [7:0] BLK_LOCK_PAIR = 8'h08;
  localparam logic [7:0] BLK_LOCK_LAST = 8'h0f;
  localparam logic [7:0] BLK_USER_LAST = 8'h3f;
  localparam logic [7:0] BLK_SYSTEM = 8'hff;
  localparam int USER_DEPTH = 64;
  // field positions
  localparam int RELOAD_MSB = 31;
  localparam int RELOAD_LSB = 21;
  localparam int LOCK_LSB = 24;
  localparam int LOCK_W = 8;
  localparam int ID_W = 8;
  // delivered contents
  localparam logic [31:0] CNT_A_INIT = 32'hfffffffe;
  localparam logic [31:0] CNT_RELOAD_INIT = 32'hffffffff;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  localparam logic [31:0] EMPTY_WORD = 32'h00000000;
  // request frame lengths in bytes, checksum included
  localparam logic [3:0] LEN_SELECT = 4'h4;
  localparam logic [3:0] LEN_READ = 4'h4;
  localparam logic [3:0] LEN_WRITE = 4'h8;
  localparam logic [3:0] RX_BUF_DEPTH = 4'h8;
  // character layout
  localparam int CHAR_W = 10;
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
  // checksum
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // select identifier generator
  localparam logic [7:0] LFSR_SEED = 8'h5a;
  localparam logic [7:0] LFSR_TAPS = 8'hb8;
  // reply element positions
  localparam logic [2:0] TX_SOF = 3'h0;
  localparam logic [2:0] TX_DATA_LAST = 3'h4;
  localparam logic [2:0] TX_CRC_LO = 3'h5;
  localparam logic [2:0] TX_EOF = 3'h7;
  typedef enum logic [2:0] {SM_IDLE, SM_RX, SM_DECODE, SM_PROG, SM_TX} tmwc_state_t;
endpackage

// >>> tmwc_crc_if.sv
/*
  Carrier between the control logic and the checksum engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tmwc_crc_if;
  logic init;
  logic upd;
  logic [7:0] data;
  logic [15:0] crc;
  modport user (output init, output upd, output data, input crc);
  modport engine (input init, input upd, input data, output crc);
endinterface

// >>> tmwc_crc.sv
/*
  Reflected 16-bit checksum engine, one byte per clock, no final inversion.
  Assumes init and upd are never high together.
*/
`timescale 1ns/1ps
module tmwc_crc
  import tmwc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  tmwc_crc_if.engine crc_io
);
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;

  always_comb begin
    nxt_crc = crc_ff ^ {8'h00, crc_io.data};
    for (int i = 0; i < 8; i++) begin
      nxt_crc = nxt_crc[0] ? ((nxt_crc >> 1) ^ CRC_POLY) : (nxt_crc >> 1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst || crc_io.init) begin
      crc_ff <= CRC_INIT;
    end else if (crc_io.upd) begin
      crc_ff <= nxt_crc;
    end
  end

  assign crc_io.crc = crc_ff;
endmodule

// >>> tmwc_top.sv
/*
  Write control for the 32-bit block memory of a contactless tag: request
  framing, select, block read and block write with the per-area update rules.
  Assumes decoded request characters and reply characters at the pins, and a
  power-on reset that follows field presence. Stored blocks survive srst.
*/
`timescale 1ns/1ps
module tmwc_top
  import tmwc_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES,
  parameter bit FIXED_ID_OPTION = 1'b0,
  parameter logic [31:0] SYSTEM_INIT = ERASED_WORD
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic mfg_load,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic rx_valid,
  input wire logic [tmwc_pkg::CHAR_W-1:0] rx_char,
  input wire logic tx_ready,
  output logic tx_valid_ff,
  output logic tx_sof_ff,
  output logic tx_eof_ff,
  output logic [tmwc_pkg::CHAR_W-1:0] tx_char_ff,
  output logic busy_ff,
  output logic selected_ff,
  output logic reload_armed_ff,
  output logic [tmwc_pkg::ID_W-1:0] select_identifier_ff
);
  import tmwc_pkg::*;

  localparam int PCW = $clog2(PROG_CNT + 1);
  localparam logic [PCW-1:0] PROG_LOAD = PCW'(PROG_CNT - 1);

  tmwc_state_t state_ff;
  tmwc_state_t nxt_state;
  logic [BLK_W-1:0] mem_ff [0:USER_DEPTH-1];
  logic [BLK_W-1:0] sys_ff;
  logic [7:0] rx_buf_ff [0:RX_BUF_DEPTH-1];
  logic [3:0] rx_cnt_ff;
  logic rx_bad_ff;
  logic [7:0] pend_addr_ff;
  logic [BLK_W-1:0] pend_word_ff;
  logic [PCW-1:0] prog_cnt_ff;
  logic [BLK_W-1:0] tx_word_ff;
  logic [2:0] tx_idx_ff;
  logic [7:0] lfsr_ff;
  logic id_valid_ff;

  tmwc_crc_if crc_if ();

  tmwc_crc u_crc (
    .clock(clock),
    .srst(srst),
    .crc_io(crc_if.engine)
  );

  // request characters
  wire rx_start = (state_ff == SM_IDLE) && rx_sof;
  wire rx_take = (state_ff == SM_RX) && rx_valid;
  wire char_ok = (rx_char[0] == START_LEVEL) && (rx_char[CHAR_W-1] == STOP_LEVEL);
  wire [7:0] rx_byte = rx_char[8:1];
  wire rx_room = rx_cnt_ff < RX_BUF_DEPTH;
  wire rx_end = (state_ff == SM_RX) && rx_eof && !rx_valid;

  // decoded request
  wire [7:0] cmd = rx_buf_ff[0];
  wire [7:0] blk_addr = rx_buf_ff[1];
  wire [BLK_W-1:0] wr_data = {rx_buf_ff[5], rx_buf_ff[4], rx_buf_ff[3], rx_buf_ff[2]};
  wire frame_ok = !rx_bad_ff && (crc_if.crc == CRC_RESIDUE);
  wire in_decode = state_ff == SM_DECODE;

  // block classes
  wire is_otp = blk_addr <= BLK_OTP_LAST;
  wire is_cnt = (blk_addr == BLK_CNT_A) || (blk_addr == BLK_CNT_RELOAD);
  wire is_user = (blk_addr >= BLK_USER_FIRST) && (blk_addr <= BLK_USER_LAST);
  wire is_sys = blk_addr == BLK_SYSTEM;
  wire is_mapped = (blk_addr <= BLK_USER_LAST) || is_sys;
  wire [BLK_W-1:0] old_word = is_sys ? sys_ff : (is_mapped ? mem_ff[blk_addr[5:0]] : EMPTY_WORD);
  wire old_empty = old_word == EMPTY_WORD;

  wire in_lock_range = (blk_addr >= BLK_USER_FIRST) && (blk_addr <= BLK_LOCK_LAST);
  wire [2:0] lock_idx = (blk_addr <= BLK_LOCK_PAIR) ? 3'h0 : 3'(blk_addr - BLK_LOCK_PAIR);
  wire [LOCK_W-1:0] lock_field = sys_ff[LOCK_LSB +: LOCK_W];
  wire user_locked = in_lock_range && !lock_field[lock_idx];

  wire cnt_ok = !old_empty && (wr_data < old_word);
  wire [BLK_W-1:0] otp_word = reload_armed_ff ? wr_data : (old_word & wr_data);
  wire otp_ok = reload_armed_ff || !old_empty;
  wire [BLK_W-1:0] sys_word = old_word & wr_data;

  // user blocks take the written word
  wire [BLK_W-1:0] wr_word = is_otp ? otp_word : (is_sys ? sys_word : wr_data);
  wire wr_accept = is_otp ? otp_ok :
                   is_cnt ? cnt_ok :
                   is_user ? !user_locked :
                   is_sys ? !old_empty : 1'b0;

  wire is_select = in_decode && frame_ok && (cmd == CMD_SELECT) && (rx_cnt_ff == LEN_SELECT);
  wire id_match = blk_addr == select_identifier_ff;
  wire is_read = in_decode && frame_ok && selected_ff && (cmd == CMD_READ) && (rx_cnt_ff == LEN_READ) && is_mapped;
  wire is_write = in_decode && frame_ok && selected_ff && (cmd == CMD_WRITE) && (rx_cnt_ff == LEN_WRITE) && wr_accept;

  // programming cycle
  wire prog_done = prog_cnt_ff == '0;
  wire commit = (state_ff == SM_PROG) && prog_done;
  wire [BLK_W-1:0] pend_old = mem_ff[pend_addr_ff[5:0]];
  wire reload_change = (pend_addr_ff == BLK_CNT_RELOAD) &&
                       (pend_word_ff[RELOAD_MSB:RELOAD_LSB] != pend_old[RELOAD_MSB:RELOAD_LSB]);

  // reply sequencing
  wire tx_adv = (state_ff == SM_TX) && tx_valid_ff && tx_ready;
  wire [2:0] tx_nxt_idx = tx_idx_ff + 3'h1;
  wire tx_nxt_data = (tx_nxt_idx != TX_SOF) && (tx_nxt_idx <= TX_DATA_LAST);
  wire [1:0] tx_sel = 2'(tx_nxt_idx - 3'h1);
  wire [7:0] tx_byte = tx_word_ff[{tx_sel, 3'h0} +: 8];
  // checksum sent inverted, low byte first
  wire [7:0] tx_crc_byte = (tx_nxt_idx == TX_CRC_LO) ? ~crc_if.crc[7:0] : ~crc_if.crc[15:8];
  wire [7:0] tx_out_byte = tx_nxt_data ? tx_byte : tx_crc_byte;
  wire [CHAR_W-1:0] tx_frame = {STOP_LEVEL, tx_out_byte, START_LEVEL};

  // the engine is shared: requests and replies never overlap
  assign crc_if.init = rx_start || is_read;
  assign crc_if.upd = (rx_take && char_ok && rx_room) || (tx_adv && tx_nxt_data);
  assign crc_if.data = rx_take ? rx_byte : tx_byte;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SM_IDLE: begin
        if (rx_sof) begin
          nxt_state = SM_RX;
        end
      end
      SM_RX: begin
        if (rx_end) begin
          nxt_state = SM_DECODE;
        end
      end
      SM_DECODE: begin
        if (is_read) begin
          nxt_state = SM_TX;
        end else if (is_write) begin
          nxt_state = SM_PROG;
        end else begin
          nxt_state = SM_IDLE;
        end
      end
      SM_PROG: begin
        if (prog_done) begin
          nxt_state = SM_IDLE;
        end
      end
      SM_TX: begin
        if (tx_adv && (tx_idx_ff == TX_EOF)) begin
          nxt_state = SM_IDLE;
        end
      end
      default: begin
        nxt_state = SM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= SM_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // a frame opens on SOF and closes on EOF
  always_ff @(posedge clock) begin
    if (srst || rx_start) begin
      rx_cnt_ff <= 4'h0;
      rx_bad_ff <= 1'b0;
    end else if (rx_take) begin
      rx_bad_ff <= rx_bad_ff || !char_ok || !rx_room;
      if (char_ok && rx_room) begin
        rx_buf_ff[rx_cnt_ff[2:0]] <= rx_byte;
        rx_cnt_ff <= rx_cnt_ff + 4'h1;
      end
    end
  end

  // the word is staged and only lands when the cycle completes
  always_ff @(posedge clock) begin
    if (is_write) begin
      pend_addr_ff <= blk_addr;
      pend_word_ff <= wr_word;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || is_write) begin
      prog_cnt_ff <= PROG_LOAD;
    end else if ((state_ff == SM_PROG) && !prog_done) begin
      prog_cnt_ff <= prog_cnt_ff - PCW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_state == SM_PROG;
    end
  end

  // storage is not cleared by srst; mfg_load writes the delivered image
  always_ff @(posedge clock) begin
    if (mfg_load) begin
      for (int i = 0; i < USER_DEPTH; i++) begin
        mem_ff[i] <= ERASED_WORD;
      end
      mem_ff[BLK_CNT_A[5:0]] <= CNT_A_INIT;
      mem_ff[BLK_CNT_RELOAD[5:0]] <= CNT_RELOAD_INIT;
      sys_ff <= SYSTEM_INIT;
    end else if (commit) begin
      // counters live in the block array
      if (pend_addr_ff == BLK_SYSTEM) begin
        sys_ff <= pend_word_ff;
      end else begin
        mem_ff[pend_addr_ff[5:0]] <= pend_word_ff;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reload_armed_ff <= 1'b0;
    end else if (is_select) begin
      reload_armed_ff <= 1'b0;
    end else if (commit && reload_change) begin
      reload_armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      selected_ff <= 1'b0;
    end else if (is_select) begin
      // only a matching select opens memory access
      selected_ff <= id_match;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lfsr_ff <= LFSR_SEED;
    end else begin
      lfsr_ff <= (lfsr_ff >> 1) ^ (lfsr_ff[0] ? LFSR_TAPS : 8'h00);
    end
  end

  // the identifier is caught at the first SOF; without FIXED_ID_OPTION reader timing seeds it from the LFSR, with it the system block supplies it
  always_ff @(posedge clock) begin
    if (srst) begin
      id_valid_ff <= 1'b0;
      select_identifier_ff <= 8'h00;
    end else if (rx_start && !id_valid_ff) begin
      id_valid_ff <= 1'b1;
      select_identifier_ff <= FIXED_ID_OPTION ? sys_ff[ID_W-1:0] : lfsr_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (is_read) begin
      tx_word_ff <= old_word;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_valid_ff <= 1'b0;
      tx_sof_ff <= 1'b0;
      tx_eof_ff <= 1'b0;
      tx_char_ff <= '0;
      tx_idx_ff <= TX_SOF;
    end else if (is_read) begin
      tx_valid_ff <= 1'b1;
      tx_sof_ff <= 1'b1;
      tx_eof_ff <= 1'b0;
      tx_char_ff <= '0;
      tx_idx_ff <= TX_SOF;
    end else if (tx_adv) begin
      tx_idx_ff <= tx_nxt_idx;
      tx_sof_ff <= 1'b0;
      tx_valid_ff <= tx_idx_ff != TX_EOF;
      tx_eof_ff <= tx_nxt_idx == TX_EOF;
      tx_char_ff <= (tx_nxt_idx == TX_EOF) ? '0 : tx_frame;
    end
  end

  cnt_monotone_a: assert property (@(posedge clock) disable iff (srst)
    (commit && ((pend_addr_ff == BLK_CNT_A) || (pend_addr_ff == BLK_CNT_RELOAD))) |-> (pend_word_ff < pend_old))
    else $error("counter written with a value not below the old one");
  cnt_exhausted_a: assert property (@(posedge clock) disable iff (srst || mfg_load)
    (mem_ff[BLK_CNT_A[5:0]] == EMPTY_WORD) |=> (mem_ff[BLK_CNT_A[5:0]] == EMPTY_WORD))
    else $error("exhausted counter changed");
  tear_hold_a: assert property (@(posedge clock) disable iff (srst || mfg_load)
    ((state_ff == SM_PROG) && !prog_done) |=> $stable(mem_ff[pend_addr_ff[5:0]]) && $stable(sys_ff))
    else $error("block changed before programming completed");
  reload_arm_a: assert property (@(posedge clock) disable iff (srst)
    (commit && reload_change) |=> reload_armed_ff)
    else $error("reload field change did not arm erase");
  reload_clear_a: assert property (@(posedge clock) disable iff (srst)
    is_select |=> !reload_armed_ff)
    else $error("select left erase mode armed");
  user_erase_a: assert property (@(posedge clock) disable iff (srst)
    (is_write && is_user) |=> (pend_word_ff == $past(wr_data)) ##[1:2] (state_ff == SM_PROG))
    else $error("user block word differs from written word");
  lock_reject_a: assert property (@(posedge clock) disable iff (srst)
    (in_decode && user_locked) |=> (state_ff != SM_PROG))
    else $error("locked block started programming");
  sys_clear_a: assert property (@(posedge clock) disable iff (srst)
    !$past(mfg_load) |-> ((sys_ff & ~$past(sys_ff)) == EMPTY_WORD))
    else $error("system block bit went from zero to one");
  silent_drop_a: assert property (@(posedge clock) disable iff (srst)
    (in_decode && !frame_ok) |=> (state_ff == SM_IDLE) && !tx_valid_ff)
    else $error("bad frame produced activity");
  tx_char_a: assert property (@(posedge clock) disable iff (srst)
    (tx_valid_ff && !tx_sof_ff && !tx_eof_ff) |-> (tx_char_ff[0] == START_LEVEL) && tx_char_ff[CHAR_W-1])
    else $error("reply character framing wrong");
endmodule

// >>> tmwc_reader.sv
/*
  Reader model for the tag memory write control block: sends request
  frames and collects replies. Assumes the tag samples on the rising edge.
*/
`timescale 1ns/1ps
module tmwc_reader (
  input wire logic clock,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_valid,
  output logic [9:0] rx_char,
  output logic tx_ready,
  input wire logic tx_valid_ff,
  input wire logic tx_sof_ff,
  input wire logic tx_eof_ff,
  input wire logic [9:0] tx_char_ff
);
  initial begin
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_valid = 1'b0;
    rx_char = 10'h155;
    tx_ready = 1'b0;
  end

  function automatic logic [15:0] crc_of(input logic [7:0] b [0:7], input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return ~c;
  endfunction

  task automatic send(input logic [7:0] b [0:7], input int n, input bit bad);
    logic [15:0] c;
    c = crc_of(b, n) ^ {15'h0000, bad};
    b[n] = c[7:0];
    b[n + 1] = c[15:8];
    @(posedge clock);
    rx_sof <= 1'b1;
    for (int i = 0; i < n + 2; i++) begin
      @(posedge clock);
      rx_sof <= 1'b0;
      rx_valid <= 1'b1;
      rx_char <= {1'b1, b[i], 1'b0};
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    // released line shows the inverse, so a stale char never looks valid
    rx_char <= ~rx_char;
    rx_eof <= 1'b1;
    @(posedge clock);
    rx_eof <= 1'b0;
  endtask

  task automatic get_reply(input bit slow, output logic [31:0] d, output bit ok);
    logic [7:0] e [0:7];
    int k;
    int w;
    k = 0;
    w = 0;
    ok = 1'b1;
    tx_ready <= 1'b1;
    while (k < 8 && w < 300) begin
      @(posedge clock);
      w++;
      if (tx_ready && tx_valid_ff === 1'b1) begin
        e[k] = tx_char_ff[8:1];
        if (tx_sof_ff !== (k == 0) || tx_eof_ff !== (k == 7)) ok = 1'b0;
        if (k > 0 && k < 7 && (tx_char_ff[0] !== 1'b0 || tx_char_ff[9] !== 1'b1)) ok = 1'b0;
        k++;
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    tx_ready <= 1'b0;
    d = {e[4], e[3], e[2], e[1]};
    if (k < 8) ok = 1'b0;
    if ({e[6], e[5]} !== crc_of('{e[1], e[2], e[3], e[4], 8'h00, 8'h00, 8'h00, 8'h00}, 4)) ok = 1'b0;
  endtask
endmodule

// >>> tmwc_bench.sv
/*
  Self-checking bench for the tag memory write control block.
  Assumes the reader model drives the request side and takes replies.
*/
`timescale 1ns/1ps
module tmwc_bench;
  import tmwc_pkg::*;
  localparam int PCNT = 8;
  typedef struct {logic [7:0] blk; logic [31:0] wd; logic [31:0] ex; logic acc;} tmwc_row_t;
  logic clock;
  logic srst = 1'b1;
  logic mfg_load = 1'b1;
  logic rx_sof;
  logic rx_eof;
  logic rx_valid;
  logic [9:0] rx_char;
  logic tx_ready;
  logic tx_valid_ff;
  logic tx_sof_ff;
  logic tx_eof_ff;
  logic [9:0] tx_char_ff;
  logic busy_ff;
  logic selected_ff;
  logic reload_armed_ff;
  logic [7:0] select_identifier_ff;
  int n_mismatch = 0;
  int tests_run = 0;
  // block, written word, word read back, accepted
  tmwc_row_t rows [18] = '{
    '{8'h05, 32'hfffffffd, 32'hfffffffd, 1'b1}, '{8'h05, 32'hfffffffd, 32'hfffffffd, 1'b0},
    '{8'h05, 32'hffffffff, 32'hfffffffd, 1'b0}, '{8'h05, 32'hfffffff5, 32'hfffffff5, 1'b1},
    '{8'h06, 32'hfffffffe, 32'hfffffffe, 1'b1}, '{8'h00, 32'h0000ffff, 32'h0000ffff, 1'b1},
    '{8'h00, 32'hffff00ff, 32'h000000ff, 1'b1}, '{8'h07, 32'h12345678, 32'h12345678, 1'b1},
    '{8'h07, 32'h0f0f0f0f, 32'h0f0f0f0f, 1'b1}, '{8'h3f, 32'ha5a5a5a5, 32'ha5a5a5a5, 1'b1},
    '{8'hff, 32'h7effff3c, 32'h7effff3c, 1'b1}, '{8'h07, 32'h00000000, 32'h0f0f0f0f, 1'b0},
    '{8'h08, 32'h11111111, 32'hffffffff, 1'b0}, '{8'h0f, 32'h00000000, 32'hffffffff, 1'b0},
    '{8'h09, 32'h22222222, 32'h22222222, 1'b1}, '{8'hff, 32'hffffffff, 32'h7effff3c, 1'b1},
    '{8'hff, 32'h00000000, 32'h00000000, 1'b1}, '{8'hff, 32'hffffffff, 32'h00000000, 1'b0}};

  tmwc_top #(.PROG_CNT(PCNT), .FIXED_ID_OPTION(1'b1), .SYSTEM_INIT(32'hffffff3c)) dut (
    .clock(clock), .srst(srst), .mfg_load(mfg_load), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_valid(rx_valid), .rx_char(rx_char), .tx_ready(tx_ready), .tx_valid_ff(tx_valid_ff),
    .tx_sof_ff(tx_sof_ff), .tx_eof_ff(tx_eof_ff), .tx_char_ff(tx_char_ff), .busy_ff(busy_ff),
    .selected_ff(selected_ff), .reload_armed_ff(reload_armed_ff),
    .select_identifier_ff(select_identifier_ff));
  tmwc_reader rdr (
    .clock(clock), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_valid(rx_valid), .rx_char(rx_char),
    .tx_ready(tx_ready), .tx_valid_ff(tx_valid_ff), .tx_sof_ff(tx_sof_ff), .tx_eof_ff(tx_eof_ff),
    .tx_char_ff(tx_char_ff));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // whole new word carried in a write
  task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic [31:0] d, input bit bad);
    logic [7:0] b [0:7];
    b = '{c, a, d[7:0], d[15:8], d[23:16], d[31:24], 8'h00, 8'h00};
    rdr.send(b, (c == CMD_WRITE) ? 6 : 2, bad);
  endtask

  task automatic sel(input logic [7:0] id);
    cmd(CMD_SELECT, id, 32'h0, 1'b0);
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic acc);
    cmd(CMD_WRITE, a, d, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    check("busy", busy_ff, acc);
    repeat (PCNT + 4) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input bit slow, input logic [31:0] ex);
    logic [31:0] d;
    bit ok;
    cmd(CMD_READ, a, 32'h0, 1'b0);
    rdr.get_reply(slow, d, ok);
    check("reply frame", ok, 1'b1);
    check("read data", d, ex);
  endtask

  // a dropped frame shows neither a reply nor a programming cycle
  task automatic quiet(input string what);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge clock);
      seen = seen | tx_valid_ff | busy_ff;
    end
    check(what, seen, 1'b0);
  endtask

  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    mfg_load <= 1'b0;
    @(posedge clock);
    #1;
    check("reset state", {tx_valid_ff, busy_ff, selected_ff, reload_armed_ff}, 4'h0);
    sel(8'h3c);
    check("fixed id", select_identifier_ff, 8'h3c);
    check("selected", selected_ff, 1'b1);
    rd(BLK_CNT_A, 1'b0, 32'hfffffffe);
    rd(BLK_CNT_RELOAD, 1'b1, 32'hffffffff);
    foreach (rows[i]) begin
      wr(rows[i].blk, rows[i].wd, rows[i].acc);
      rd(rows[i].blk, i[0], rows[i].ex);
      $display("row %0d done", i);
    end
    check("armed after same field", reload_armed_ff, 1'b0);
    wr(BLK_CNT_RELOAD, 32'hffdfffff, 1'b1);
    check("armed", reload_armed_ff, 1'b1);
    wr(8'h00, 32'h12345678, 1'b1);
    rd(8'h00, 1'b0, 32'h12345678);
    sel(8'h3c);
    check("disarmed", reload_armed_ff, 1'b0);
    wr(8'h00, 32'hffffff00, 1'b1);
    rd(8'h00, 1'b0, 32'h12345600);
    $display("reload test done");
    wr(BLK_CNT_A, 32'h00000000, 1'b1);
    wr(BLK_CNT_A, 32'h00000000, 1'b0);
    rd(BLK_CNT_A, 1'b1, 32'h00000000);
    $display("exhaust test done");
    // power loss in mid-programming, erase armed
    wr(BLK_CNT_RELOAD, 32'hffbfffff, 1'b1);
    check("armed before loss", reload_armed_ff, 1'b1);
    cmd(CMD_WRITE, BLK_CNT_RELOAD, 32'h00000005, 1'b0);
    repeat (5) @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1;
    check("torn state", {busy_ff, selected_ff, reload_armed_ff, select_identifier_ff}, 11'h000);
    cmd(CMD_READ, BLK_CNT_RELOAD, 32'h0, 1'b0);
    quiet("unselected read");
    sel(8'h00);
    check("id from empty block", select_identifier_ff, 8'h00);
    rd(BLK_CNT_RELOAD, 1'b0, 32'hffbfffff);
    $display("tearing test done");
    cmd(CMD_READ, 8'h07, 32'h0, 1'b1);
    quiet("bad checksum");
    cmd(8'h55, 8'h07, 32'h0, 1'b0);
    quiet("unknown command");
    rd(8'h07, 1'b1, 32'h0f0f0f0f);
    sel(8'h77);
    check("deselected", selected_ff, 1'b0);
    $display("frame test done");
    close_out();
  end
endmodule
